// [verilog/shift_exec_defs.vh]
// constants for the shift, flag and skip execution block
// assumes a 32-bit AHB-Lite register window, byte addressed
`ifndef SHIFT_EXEC_DEFS_VH
`define SHIFT_EXEC_DEFS_VH

// register byte offsets
`define REG_INSTR       8'h00
`define REG_STATUS      8'h04
`define REG_PROG_CNT    8'h08
`define REG_MEM_ADDR    8'h0C
`define REG_MEM_DATA    8'h10

// status register fields
`define ST_ACCUM_LSB    0
`define ST_ACCUM_MSB    3
`define ST_CARRY        4
`define ST_ZERO         5
`define ST_WDT_SLOW     6
`define ST_BUSY         7

// reset values
`define RST_ACCUM       4'h0
`define RST_PROG_CNT    11'h000
`define RST_INSTR       16'h0000

// instruction opcodes, upper bits of the 16-bit word; set-carry is the whole word
`define OP_SHL_HI       9'h098
`define OP_SHR_HI       9'h09A
`define OP_SKIP0_HI     9'h110
`define OP_SKIP1_HI     9'h111
`define OP_PARAM_HI     12'h160
`define OP_SETCF        16'h5020
`define PARAM_WDT_BIT   3

// watchdog clock dividers
`define WDT_SLOW_DIV    16384
`define WDT_FAST_DIV    1024

// read wait states
`define RD_WAIT_REG     2'h1
`define RD_WAIT_MEM     2'h2

`endif

// [verilog/data_nibble_ram.v]
// 128 x 4 data memory with registered read data
// assumes one clock; read data follows the address by one edge
`timescale 1ns/1ps
module data_nibble_ram (
	input  wire       hclk,
	input  wire       we,
	input  wire [6:0] addr,
	input  wire [3:0] wdata,
	output reg  [3:0] rdata
);
	reg [3:0] mem [0:127];

	always @(posedge hclk) begin
		if (we)
			mem[addr] <= wdata;
		rdata <= mem[addr];
	end
endmodule

// [verilog/shift_flag_skip_exec.v]
// execution unit for set-carry, set-parameter-flag, shift and bit-skip
// assumes a single AHB-Lite master; the slave's hreadyout is hready
`timescale 1ns/1ps
`include "shift_exec_defs.vh"

// Summary of operation
// [RULE1] set-carry forces carry_flag to one, other flags untouched
// [RULE2] parameter flag bit three selects watchdog clock of Fosc/16384
// [RULE3] parameter flag immediate bits zero to two have no function
// [RULE4] shift left: old bit 3 to carry, zero into bit 0, to ram, accumulator
// [RULE5] shift right: old bit 0 to carry, zero into bit 3, to ram, accumulator
// [RULE6] shift operand is the nibble at the seven-bit address field
// [RULE7] skip-on-bit-0 adds two to program counter if bit 0 set, else one
// [RULE8] skip-on-bit-1 adds two to program counter if bit 1 set, else one
// [RULE9] shifts set zero_flag on zero result; each op is one machine cycle
module shift_flag_skip_exec #(
	parameter WDT_SLOW_DIV = `WDT_SLOW_DIV,
	parameter WDT_FAST_DIV = `WDT_FAST_DIV
) (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output wire        hreadyout,
	output wire        hresp,
	output reg         wdt_tick
);
	localparam S_IDLE  = 3'b001;
	localparam S_FETCH = 3'b010;
	localparam S_EXEC  = 3'b100;

	reg  [2:0]  state_r;
	reg  [15:0] instr_r;
	reg  [3:0]  accumulator_nibble;
	reg         carry_flag;
	reg         zero_flag;
	reg         wdt_slow_r;
	reg  [10:0] program_counter;
	reg  [6:0]  mem_addr_r;
	reg         dp_valid_r;
	reg         dp_write_r;
	reg  [7:0]  dp_addr_r;
	reg  [1:0]  rd_cnt_r;
	reg  [13:0] wdt_cnt_r;

	wire        busy;
	wire        wr_en;
	wire [1:0]  rd_need;
	wire [6:0]  memory_address_field;
	wire [3:0]  ram_q;
	wire        ram_we;
	wire [6:0]  ram_addr;
	wire [3:0]  ram_wdata;
	wire [4:0]  shl_res;
	wire [4:0]  shr_res;
	wire        is_shl;
	wire        is_shr;
	wire        is_skip0;
	wire        is_skip1;
	wire        is_param;
	wire        is_setcf;
	wire [13:0] wdt_lim;

	// returns {carry_out, result} of a zero-fill shift
	function [4:0] shift_zero_fill;
		input       left;
		input [3:0] val;
		begin
			if (left)
				shift_zero_fill = {val[3], val[2:0], 1'b0};
			else
				shift_zero_fill = {val[0], 1'b0, val[3:1]};
		end
	endfunction

	function [31:0] reg_read;
		input [7:0] a;
		begin
			case (a)
			`REG_INSTR:    reg_read = {16'h0000, instr_r};
			`REG_STATUS:   reg_read = {24'h000000, busy, wdt_slow_r,
					zero_flag, carry_flag, accumulator_nibble};
			`REG_PROG_CNT: reg_read = {21'h000000, program_counter};
			`REG_MEM_ADDR: reg_read = {25'h0000000, mem_addr_r};
			`REG_MEM_DATA: reg_read = {28'h0000000, ram_q};
			default:       reg_read = 32'h00000000;
			endcase
		end
	endfunction

	assign busy    = (state_r != S_IDLE);
	assign rd_need = (dp_addr_r == `REG_MEM_DATA) ? `RD_WAIT_MEM
		: `RD_WAIT_REG;
	// data phases stall while an instruction is in flight
	assign hreadyout = !dp_valid_r ||
		(!busy && (dp_write_r || (rd_cnt_r == rd_need)));
	assign hresp = 1'b0;
	assign wr_en = dp_valid_r && dp_write_r && hreadyout;

	assign memory_address_field = instr_r[6:0];
	assign is_shl   = (instr_r[15:7] == `OP_SHL_HI);
	assign is_shr   = (instr_r[15:7] == `OP_SHR_HI);
	assign is_skip0 = (instr_r[15:7] == `OP_SKIP0_HI);
	assign is_skip1 = (instr_r[15:7] == `OP_SKIP1_HI);
	assign is_param = (instr_r[15:4] == `OP_PARAM_HI);
	assign is_setcf = (instr_r == `OP_SETCF);
	assign shl_res  = shift_zero_fill(1'b1, ram_q); // RULE4
	assign shr_res  = shift_zero_fill(1'b0, ram_q); // RULE5

	// operand nibble addressed by the instruction while busy
	assign ram_addr = busy ? memory_address_field : mem_addr_r; // RULE6
	assign ram_we = (state_r == S_EXEC && (is_shl || is_shr)) ||
		(wr_en && dp_addr_r == `REG_MEM_DATA);
	assign ram_wdata = busy ? (is_shl ? shl_res[3:0] : shr_res[3:0])
		: hwdata[3:0];

	data_nibble_ram u_ram (
		.hclk  (hclk),
		.we    (ram_we),
		.addr  (ram_addr),
		.wdata (ram_wdata),
		.rdata (ram_q)
	);

	// ahb address and data phase tracking
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_valid_r <= 1'b0;
			dp_write_r <= 1'b0;
			dp_addr_r  <= 8'h00;
			rd_cnt_r   <= 2'h0;
			hrdata     <= 32'h00000000;
		end else begin
			if (hready) begin
				dp_valid_r <= hsel && htrans[1];
				dp_write_r <= hwrite;
				dp_addr_r  <= haddr[7:0];
				rd_cnt_r   <= 2'h0;
			end else if (dp_valid_r && !dp_write_r && !busy) begin
				rd_cnt_r <= rd_cnt_r + 2'h1;
				if (rd_cnt_r == rd_need - 2'h1)
					hrdata <= reg_read(dp_addr_r);
			end
		end
	end

	// instruction sequencer and architectural state
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r            <= S_IDLE;
			instr_r            <= `RST_INSTR;
			accumulator_nibble <= `RST_ACCUM;
			carry_flag         <= 1'b0;
			zero_flag          <= 1'b0;
			wdt_slow_r         <= 1'b0;
			program_counter    <= `RST_PROG_CNT;
			mem_addr_r         <= 7'h00;
		end else begin
			case (state_r)
			S_IDLE: begin
				if (wr_en) begin
					case (dp_addr_r)
					`REG_INSTR: begin
						instr_r <= hwdata[15:0];
						state_r <= S_FETCH;
					end
					`REG_STATUS: begin
						accumulator_nibble <= hwdata[`ST_ACCUM_MSB:`ST_ACCUM_LSB];
						carry_flag <= hwdata[`ST_CARRY];
						zero_flag  <= hwdata[`ST_ZERO];
						wdt_slow_r <= hwdata[`ST_WDT_SLOW];
					end
					`REG_PROG_CNT: program_counter <= hwdata[10:0];
					`REG_MEM_ADDR: mem_addr_r <= hwdata[6:0];
					default: ;
					endcase
				end
			end
			S_FETCH: state_r <= S_EXEC;
			S_EXEC: begin
				state_r <= S_IDLE; // RULE9
				program_counter <= program_counter + 11'h001;
				if (is_setcf)
					carry_flag <= 1'b1; // RULE1
				if (is_param)
					wdt_slow_r <= instr_r[`PARAM_WDT_BIT]; // RULE2 RULE3
				if (is_shl) begin
					accumulator_nibble <= shl_res[3:0]; // RULE4
					carry_flag <= shl_res[4];
					zero_flag  <= (shl_res[3:0] == 4'h0); // RULE9
				end
				if (is_shr) begin
					accumulator_nibble <= shr_res[3:0]; // RULE5
					carry_flag <= shr_res[4];
					zero_flag  <= (shr_res[3:0] == 4'h0); // RULE9
				end
				if ((is_skip0 && ram_q[0]) || (is_skip1 && ram_q[1]))
					program_counter <= program_counter + 11'h002; // RULE7 RULE8
			end
			default: state_r <= S_IDLE;
			endcase
		end
	end

	// watchdog counting clock enable
	assign wdt_lim = wdt_slow_r ? WDT_SLOW_DIV[13:0] - 14'h0001 // RULE2
		: WDT_FAST_DIV[13:0] - 14'h0001;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wdt_cnt_r <= 14'h0000;
			wdt_tick  <= 1'b0;
		end else if (wdt_cnt_r >= wdt_lim) begin
			wdt_cnt_r <= 14'h0000;
			wdt_tick  <= 1'b1;
		end else begin
			wdt_cnt_r <= wdt_cnt_r + 14'h0001;
			wdt_tick  <= 1'b0;
		end
	end
endmodule

// [dv/shift_exec_sva.sv]
// port checker for the shift, flag and skip execution block
// assumes hready is looped back from hreadyout by the bench
`timescale 1ns/1ps
`include "shift_exec_defs.vh"
module shift_exec_sva (
	input wire        hclk,
	input wire        hresetn,
	input wire        hsel,
	input wire [31:0] haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire [2:0]  hsize,
	input wire [31:0] hwdata,
	input wire        hready,
	input wire [31:0] hrdata,
	input wire        hreadyout,
	input wire        hresp,
	input wire        wdt_tick
);
	reg       rd_r;
	reg [7:0] ad_r;
	wire      rd_end = rd_r && hreadyout;
	wire      rd_req = hsel && htrans[1] && !hwrite;
	// remembers the read whose data phase is running
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_r <= 1'b0;
			ad_r <= 8'h00;
		end else if (hreadyout) begin
			rd_r <= rd_req;
			ad_r <= haddr[7:0];
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("error response seen");
	a_tick_single: assert property (wdt_tick |=> !wdt_tick [*8])
		else $error("watchdog ticks too close");
	a_read_waits: assert property (hreadyout && rd_req |=> !hreadyout)
		else $error("read without wait state");
	a_wait_bounded: assert property (!hreadyout |-> ##[1:5] hreadyout)
		else $error("wait state too long");
	a_word_fields: assert property (rd_end |-> hrdata[31:16] == 16'h0000)
		else $error("upper read bits set");
	a_nibble_read: assert property (rd_end && ad_r == `REG_MEM_DATA
		|-> hrdata[31:4] == 28'h0000000) else $error("nibble read too wide");
	a_status_idle: assert property (rd_end && ad_r == `REG_STATUS
		|-> hrdata[31:7] == 25'h0000000) else $error("status busy at read");
	a_count_width: assert property (rd_end && ad_r == `REG_PROG_CNT
		|-> hrdata[31:11] == 21'h000000) else $error("counter read too wide");
	cover property (rd_end && ad_r == `REG_MEM_DATA);
	cover property (wdt_tick);
	cover property (!hreadyout ##1 !hreadyout ##1 !hreadyout);
endmodule
bind shift_flag_skip_exec shift_exec_sva chk (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .wdt_tick(wdt_tick));

// [dv/tb_top.sv]
// self-checking bench for the shift, flag and skip execution block
// assumes hready looped back from hreadyout; short watchdog divisors
`timescale 1ns/1ps
`include "shift_exec_defs.vh"
module tb_top;
	logic        hclk, hresetn, hsel, hwrite, rdp, hreadyout, hresp, wdt_tick;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	localparam int SLOW_DIV = 64;
	localparam int FAST_DIV = 16;
	logic [31:0] expq[$];
	logic [31:0] tq[$];
	string       nmq[$];
	int          err_total, samples_checked, op, gap;
	logic [3:0]  a_exp, v, r, im;
	logic        c_exp, z_exp, wsl;
	logic [10:0] cnt_exp;
	logic [6:0]  ad, st;
	logic [15:0] ins;
	shift_flag_skip_exec #(
		.WDT_SLOW_DIV(SLOW_DIV),
		.WDT_FAST_DIV(FAST_DIV)
	) uut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .wdt_tick(wdt_tick));
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h000000, a};
		@(posedge hclk iff hreadyout);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk iff hreadyout);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
		expq.push_back(e);
		nmq.push_back(n);
		bus(1'b0, a, 32'h00000000);
	endtask
	// notes the expected spacing of two watchdog ticks after a setting
	task automatic tick_gap(input logic [31:0] e);
		repeat (2) @(posedge hclk);
		@(posedge hclk iff wdt_tick);
		@(posedge hclk);
		tq.push_back(e);
		@(posedge hclk iff wdt_tick);
		@(posedge hclk);
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
		samples_checked++;
		if (s !== e) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// takes the oldest note whenever a read data phase ends
	always @(posedge hclk) begin
		if (hreadyout) begin
			if (rdp)
				chk(hrdata, expq.pop_front(), nmq.pop_front());
			rdp <= hsel && htrans[1] && !hwrite;
		end
		// cycles between watchdog ticks, checked against the oldest note
		if (wdt_tick) begin
			if (tq.size() > 0)
				chk(gap, tq.pop_front(), "tick gap");
			gap <= 1;
		end else begin
			gap <= gap + 1;
		end
	end
	initial begin
		#200000;
		err_total++;
		conclude;
	end
	initial begin
		{hsel, hwrite, htrans, haddr, hwdata, rdp} = '0;
		hsize = 3'h2;
		hresetn = 1'b0;
		{err_total, samples_checked, gap} = '0;
		{a_exp, c_exp, z_exp, wsl, cnt_exp} = '0;
		void'($urandom(32'h322DF530));
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(`REG_STATUS, 32'h00000000, "status reset");
		rd(`REG_PROG_CNT, 32'h00000000, "counter reset");
		rd(8'h20, 32'h00000000, "unmapped read");
		for (int i = 0; i < 36; i++) begin
			{v, ad, im, st} = 22'($urandom);
			op = i % 6;
			bus(1'b1, `REG_MEM_ADDR, {25'h0, ad});
			bus(1'b1, `REG_MEM_DATA, {28'h0, v});
			bus(1'b1, `REG_MEM_ADDR, {25'h0, ad ^ 7'h01});
			bus(1'b1, `REG_MEM_DATA, {28'h0, ~v});
			bus(1'b1, `REG_STATUS, {25'h0, st});
			{wsl, z_exp, c_exp, a_exp} = st;
			r = v;
			case (op)
			0: r = {v[2:0], 1'b0};
			1: r = {1'b0, v[3:1]};
			4: c_exp = 1'b1;
			5: wsl = im[3];
			default: r = v;
			endcase
			ins = op == 0 ? {`OP_SHL_HI, ad} : op == 1 ? {`OP_SHR_HI, ad} :
				op == 2 ? {`OP_SKIP0_HI, ad} : op == 3 ? {`OP_SKIP1_HI, ad} :
				op == 4 ? `OP_SETCF : {`OP_PARAM_HI, im};
			if (op < 2) begin
				c_exp = op == 0 ? v[3] : v[0];
				a_exp = r;
				z_exp = r == 4'h0;
			end
			cnt_exp = cnt_exp + ((op == 2 && v[0]) || (op == 3 && v[1]) ?
				11'h002 : 11'h001);
			bus(1'b1, `REG_INSTR, {16'h0000, ins});
			rd(`REG_STATUS, {25'h0, wsl, z_exp, c_exp, a_exp}, "status");
			rd(`REG_PROG_CNT, {21'h0, cnt_exp}, "program counter");
			bus(1'b1, `REG_MEM_ADDR, {25'h0, ad});
			rd(`REG_MEM_DATA, {28'h0, r}, "nibble");
			bus(1'b1, `REG_MEM_ADDR, {25'h0, ad ^ 7'h01});
			rd(`REG_MEM_DATA, {28'h0, ~v}, "neighbour nibble");
		end
		// watchdog period under both settings of the parameter flag
		bus(1'b1, `REG_INSTR, {16'h0000, `OP_PARAM_HI, 4'h8});
		tick_gap(SLOW_DIV);
		bus(1'b1, `REG_INSTR, {16'h0000, `OP_PARAM_HI, 4'h7});
		tick_gap(FAST_DIV);
		conclude;
	end
endmodule
